// File: shared/ldo_ctrl_pkg.sv
package ldo_ctrl_pkg;

   // ------------------------------------------------------------
   // Bus geometry
   // ------------------------------------------------------------
   localparam int ADDR_W = 4;
   localparam int DATA_W = 32;

   // ------------------------------------------------------------
   // Register byte offsets
   // ------------------------------------------------------------
   localparam logic [ADDR_W-1:0] OFF_CTRL = 4'h0;
   localparam logic [ADDR_W-1:0] OFF_VOUT = 4'h4;
   localparam logic [ADDR_W-1:0] OFF_STATUS = 4'h8;
   localparam logic [ADDR_W-1:0] OFF_MASK = 4'hc;

   // ------------------------------------------------------------
   // Control register fields
   // ------------------------------------------------------------
   localparam int CTRL_ENABLE_BIT = 0;
   localparam int CTRL_STANDBY_BIT = 1;
   localparam int CTRL_SLEEP_BIT = 2;
   localparam int CTRL_LOWPWR_BIT = 3;
   localparam int CTRL_SHUTDOWN_BIT = 4;
   localparam int CTRL_W = 5;

   // ------------------------------------------------------------
   // Status / mask register fields
   // ------------------------------------------------------------
   localparam int STAT_FAULT_BIT = 0;
   localparam int STAT_W = 1;

   // ------------------------------------------------------------
   // Voltage code and set points (millivolts)
   // ------------------------------------------------------------
   localparam int VCODE_W = 4;
   localparam int MV_W = 12;
   localparam logic [MV_W-1:0] VOUT_BASE_MV = 12'd1800;
   localparam logic [MV_W-1:0] VOUT_STEP_MV = 12'd100;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h00;
   localparam logic [VCODE_W-1:0] VOUT_RESET = 4'h0;
   localparam logic [STAT_W-1:0] STAT_RESET = 1'h0;
   localparam logic [STAT_W-1:0] MASK_RESET = 1'h0;

   // ------------------------------------------------------------
   // Power states and operating modes
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      PST_RUN = 2'h0,
      PST_STANDBY = 2'h1,
      PST_SLEEP = 2'h2
   } power_state_t;

   typedef enum logic [1:0] {
      MODE_OFF = 2'h0,
      MODE_ON = 2'h1,
      MODE_LOW_POWER = 2'h2
   } op_mode_t;

endpackage

// File: core/ldo_mode_decode.sv
`timescale 1ns/1ps
`default_nettype none

module ldo_mode_decode
   import ldo_ctrl_pkg::*;
(
   // Power state and control bits
   input wire logic [1:0] power_state,
   input wire logic reg_enable,
   input wire logic standby_enable,
   input wire logic sleep_mode_enable,
   input wire logic low_power_select,
   // Decoded mode
   output op_mode_t mode
);

   always_comb begin
      mode = MODE_OFF;
      if (reg_enable) begin
         case (power_state)
            PST_RUN: mode = MODE_ON;
            PST_STANDBY: begin
               if (standby_enable) begin
                  mode = low_power_select ? MODE_LOW_POWER : MODE_ON;
               end
            end
            PST_SLEEP: begin
               if (sleep_mode_enable) begin
                  mode = low_power_select ? MODE_LOW_POWER : MODE_ON;
               end
            end
            default: mode = MODE_OFF;
         endcase
      end
   end

endmodule // ldo_mode_decode

`default_nettype wire

// File: core/ldo_vout_decode.sv
`timescale 1ns/1ps
`default_nettype none

module ldo_vout_decode
   import ldo_ctrl_pkg::*;
(
   // Code in
   input wire logic [VCODE_W-1:0] vout_code,
   // Set point out
   output logic [MV_W-1:0] vout_mv
);

   // Linear set point: base plus one step per code
   function automatic logic [MV_W-1:0] code_to_mv(input logic [VCODE_W-1:0] code);
      logic [MV_W-1:0] step;
      step = MV_W'(code) * VOUT_STEP_MV;
      return MV_W'(VOUT_BASE_MV + step);
   endfunction

   always_comb begin
      vout_mv = code_to_mv(vout_code);
   end

endmodule // ldo_vout_decode

`default_nettype wire

// File: core/ldo_regulator_control.sv
// What this block does
// - Voltage code 0 gives 1.80 V, each step adds 0.1 V, up to 3.30 V.
// - In run state the regulator follows the enable bit alone.
// - Standby with enable: off unless standby bit; low power when low-power bit.
// - Sleep with enable: off unless sleep-mode bit; low power when low-power bit.
// - Overcurrent switches the regulator into current-limit regulation while it is enabled.
// - With shutdown bit set, overcurrent clears enable and raises the fault flag.
// - The fault interrupt is blocked while its mask bit is set.
// - With shutdown bit clear, overcurrent keeps enable and stays in current limit.
// - The shutdown-on-overcurrent bit resets to zero.
// - Every overload sets the fault flag regardless of the shutdown bit.
// - Discharge pull-down on while disabled or while processor reset is low.
`timescale 1ns/1ps
`default_nettype none

module ldo_regulator_control
   import ldo_ctrl_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Avalon-MM slave
   input wire logic [ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [DATA_W-1:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [DATA_W-1:0] avs_readdata,
   output logic avs_waitrequest,
   // Power state and analog status
   input wire logic [1:0] power_state,
   input wire logic overcurrent,
   input wire logic processor_reset_out_n,
   // Regulator controls
   output logic reg_enable,
   output logic reg_low_power,
   output logic current_limit_mode,
   output logic discharge_en,
   output logic [VCODE_W-1:0] vout_code,
   output logic [MV_W-1:0] vout_mv,
   // Interrupt
   output logic irq
);

   // ------------------------------------------------------------
   // Overcurrent synchroniser and edge detect
   // ------------------------------------------------------------
   logic [1:0] oc_sync_q, oc_sync_d;
   logic oc_prev_q, oc_prev_d;
   logic oc_s, oc_rise;

   always_comb begin
      oc_sync_d = {oc_sync_q[0], overcurrent};
      oc_prev_d = oc_sync_q[1];
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         oc_sync_q <= 2'h0;
         oc_prev_q <= 1'b0;
      end else begin
         oc_sync_q <= oc_sync_d;
         oc_prev_q <= oc_prev_d;
      end
   end

   assign oc_s = oc_sync_q[1];
   // Only a fresh rise counts as a fault event
   assign oc_rise = oc_s & ~oc_prev_q;

   // ------------------------------------------------------------
   // Processor reset pin synchroniser
   // ------------------------------------------------------------
   logic [1:0] rstn_sync_q, rstn_sync_d;
   logic rstn_s;

   always_comb begin
      rstn_sync_d = {rstn_sync_q[0], processor_reset_out_n};
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rstn_sync_q <= 2'h3;
      end else begin
         rstn_sync_q <= rstn_sync_d;
      end
   end

   assign rstn_s = rstn_sync_q[1];

   // ------------------------------------------------------------
   // Power state synchroniser with stability filter
   // ------------------------------------------------------------
   // Skewed two-bit codes held off until two samples agree
   logic [1:0] pst_meta_q, pst_meta_d;
   logic [1:0] pst_sync_q, pst_sync_d;
   logic [1:0] pst_last_q, pst_last_d;
   logic [1:0] pst_q, pst_d;

   always_comb begin
      pst_meta_d = power_state;
      pst_sync_d = pst_meta_q;
      pst_last_d = pst_sync_q;
      pst_d = pst_q;
      if (pst_sync_q == pst_last_q) begin
         pst_d = pst_sync_q;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         pst_meta_q <= 2'h0;
         pst_sync_q <= 2'h0;
         pst_last_q <= 2'h0;
         pst_q <= 2'h0;
      end else begin
         pst_meta_q <= pst_meta_d;
         pst_sync_q <= pst_sync_d;
         pst_last_q <= pst_last_d;
         pst_q <= pst_d;
      end
   end

   // ------------------------------------------------------------
   // Bus handshake
   // ------------------------------------------------------------
   logic ack_q, ack_d;
   logic req;
   logic wr_hit;
   logic rd_hit;

   // One wait state on every access, mapped or not
   assign req = (avs_read | avs_write) & ~ack_q;
   assign wr_hit = avs_write & ~ack_q & avs_byteenable[0];
   assign rd_hit = avs_read & ~ack_q;

   always_comb begin
      ack_d = req;
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= ack_d;
      end
   end

   assign avs_waitrequest = req;

   // ------------------------------------------------------------
   // Control, voltage and mask registers
   // ------------------------------------------------------------
   logic [CTRL_W-1:0] ctrl_q, ctrl_d;
   logic [VCODE_W-1:0] vout_q, vout_d;
   logic [STAT_W-1:0] mask_q, mask_d;

   always_comb begin
      ctrl_d = ctrl_q;
      vout_d = vout_q;
      mask_d = mask_q;
      if (wr_hit) begin
         case (avs_address)
            OFF_CTRL: ctrl_d = avs_writedata[CTRL_W-1:0];
            OFF_VOUT: vout_d = avs_writedata[VCODE_W-1:0];
            OFF_MASK: mask_d = avs_writedata[STAT_W-1:0];
            default: ;
         endcase
      end
      // Shutdown wins over a software write in the same cycle
      if (oc_rise && ctrl_q[CTRL_SHUTDOWN_BIT]) begin
         ctrl_d[CTRL_ENABLE_BIT] = 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ctrl_q <= CTRL_RESET;
         vout_q <= VOUT_RESET;
         mask_q <= MASK_RESET;
      end else begin
         ctrl_q <= ctrl_d;
         vout_q <= vout_d;
         mask_q <= mask_d;
      end
   end

   // ------------------------------------------------------------
   // Fault status
   // ------------------------------------------------------------
   logic [STAT_W-1:0] status_q, status_d;

   always_comb begin
      status_d = status_q;
      if (rd_hit && (avs_address == OFF_STATUS)) begin
         status_d = STAT_RESET; // Read clears
      end
      // Set wins over a clearing read in the same cycle
      if (oc_rise) begin
         status_d[STAT_FAULT_BIT] = 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         status_q <= STAT_RESET;
      end else begin
         status_q <= status_d;
      end
   end

   // ------------------------------------------------------------
   // Read data
   // ------------------------------------------------------------
   logic [DATA_W-1:0] rdata_q, rdata_d;

   always_comb begin
      rdata_d = rdata_q;
      if (rd_hit) begin
         // Unmapped offsets read as zero
         case (avs_address)
            OFF_CTRL: rdata_d = DATA_W'(ctrl_q);
            OFF_VOUT: rdata_d = DATA_W'(vout_q);
            OFF_STATUS: rdata_d = DATA_W'(status_q);
            OFF_MASK: rdata_d = DATA_W'(mask_q);
            default: rdata_d = '0;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rdata_q <= '0;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   assign avs_readdata = rdata_q;

   // ------------------------------------------------------------
   // Interrupt
   // ------------------------------------------------------------
   assign irq = |(status_q & ~mask_q);

   // ------------------------------------------------------------
   // Mode decode and outputs
   // ------------------------------------------------------------
   op_mode_t mode;

   ldo_mode_decode u_mode (
      .power_state(pst_q),
      .reg_enable(ctrl_q[CTRL_ENABLE_BIT]),
      .standby_enable(ctrl_q[CTRL_STANDBY_BIT]),
      .sleep_mode_enable(ctrl_q[CTRL_SLEEP_BIT]),
      .low_power_select(ctrl_q[CTRL_LOWPWR_BIT]),
      .mode(mode)
   );

   ldo_vout_decode u_vout (
      .vout_code(vout_q),
      .vout_mv(vout_mv)
   );

   // ------------------------------------------------------------
   // Regulator output registers
   // ------------------------------------------------------------
   logic on_q, on_d;
   logic lp_q, lp_d;
   logic cl_q, cl_d;
   logic dis_q, dis_d;

   always_comb begin
      on_d = (mode != MODE_OFF);
      lp_d = (mode == MODE_LOW_POWER);
      // Current limit only while the regulator runs
      cl_d = on_d & oc_s;
      // Pull-down also while the processor is held in reset
      dis_d = ~on_d | ~rstn_s;
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         on_q <= 1'b0;
         lp_q <= 1'b0;
         cl_q <= 1'b0;
         dis_q <= 1'b1;
      end else begin
         on_q <= on_d;
         lp_q <= lp_d;
         cl_q <= cl_d;
         dis_q <= dis_d;
      end
   end

   // ------------------------------------------------------------
   // Output drive
   // ------------------------------------------------------------
   assign reg_enable = on_q;
   assign reg_low_power = lp_q;
   assign current_limit_mode = cl_q;
   assign discharge_en = dis_q;
   assign vout_code = vout_q;

endmodule // ldo_regulator_control

`default_nettype wire

// File: sim/ldo_regulator_control_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module ldo_regulator_control_asserts
   import ldo_ctrl_pkg::*;
(
   // Watched ports
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic avs_waitrequest,
   input wire logic [1:0] power_state,
   input wire logic processor_reset_out_n,
   input wire logic reg_enable,
   input wire logic reg_low_power,
   input wire logic discharge_en,
   input wire logic [VCODE_W-1:0] vout_code,
   input wire logic [MV_W-1:0] vout_mv
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   a_wait_first: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
      else $error("no wait state");
   a_ack_second: assert property ($rose(avs_read || avs_write) |=> !avs_waitrequest)
      else $error("late acknowledge");
   a_vout_map: assert property (vout_mv == VOUT_BASE_MV + VOUT_STEP_MV * MV_W'(vout_code))
      else $error("bad set point");
   a_run_full: assert property ((power_state == 2'h0) [*6] |-> !reg_low_power)
      else $error("low power in run");
   a_lp_on: assert property (reg_low_power |-> reg_enable)
      else $error("low power while off");
   a_dis_off: assert property (!reg_enable |-> discharge_en)
      else $error("no discharge while off");
   a_dis_rst: assert property (!processor_reset_out_n [*4] |-> discharge_en)
      else $error("no discharge in reset");
   a_state_off: assert property ((power_state == 2'h3) [*6] |-> !reg_enable)
      else $error("on in off state");
endmodule // ldo_regulator_control_asserts
bind ldo_regulator_control ldo_regulator_control_asserts chk_u (
   .clk_sys(clk_sys), .rst(rst), .avs_read(avs_read), .avs_write(avs_write),
   .avs_waitrequest(avs_waitrequest), .power_state(power_state),
   .processor_reset_out_n(processor_reset_out_n), .reg_enable(reg_enable),
   .reg_low_power(reg_low_power), .discharge_en(discharge_en),
   .vout_code(vout_code), .vout_mv(vout_mv)
);
`default_nettype wire

// File: sim/ldo_host_bfm.sv
`timescale 1ns/1ps
`default_nettype none
module ldo_host_bfm
   import ldo_ctrl_pkg::*;
(
   // Avalon master side
   input wire logic clk_sys,
   input wire logic waitrequest,
   input wire logic [DATA_W-1:0] readdata,
   output logic [ADDR_W-1:0] address,
   output logic read,
   output logic write,
   output logic [DATA_W-1:0] writedata
);
   initial begin
      address <= '0;
      read <= 1'b0;
      write <= 1'b0;
      writedata <= '0;
   end
   // Request held until the rising edge that samples waitrequest low
   task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic ok);
      int n;
      n = 0;
      ok = 1'b0;
      address <= a;
      read <= !wr;
      write <= wr;
      writedata <= d;
      while (!ok && n < 50) begin
         @(posedge clk_sys);
         ok = (waitrequest === 1'b0);
         q = readdata;
         n++;
      end
      read <= 1'b0;
      write <= 1'b0;
      @(posedge clk_sys);
   endtask
endmodule // ldo_host_bfm
`default_nettype wire

// File: sim/tb_ldo_regulator_control.sv
`timescale 1ns/1ps
`default_nettype none
module tb_ldo_regulator_control
   import ldo_ctrl_pkg::*;
;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic [1:0] power_state = 2'h0;
   logic overcurrent = 1'b0;
   logic processor_reset_out_n = 1'b1;
   logic [ADDR_W-1:0] avs_address;
   logic avs_read, avs_write, avs_waitrequest, ok;
   logic [DATA_W-1:0] avs_writedata, avs_readdata, rd_q;
   logic reg_enable, reg_low_power, current_limit_mode, discharge_en, irq;
   logic [VCODE_W-1:0] vout_code;
   logic [MV_W-1:0] vout_mv;
   int err_total = 0;
   int samples_checked = 0;
   always #5 clk_sys = ~clk_sys;
   ldo_regulator_control dut_u (.clk_sys(clk_sys), .rst(rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .power_state(power_state), .overcurrent(overcurrent),
      .processor_reset_out_n(processor_reset_out_n), .reg_enable(reg_enable),
      .reg_low_power(reg_low_power), .current_limit_mode(current_limit_mode),
      .discharge_en(discharge_en), .vout_code(vout_code), .vout_mv(vout_mv), .irq(irq));
   ldo_host_bfm bfm_u (.clk_sys(clk_sys), .waitrequest(avs_waitrequest),
      .readdata(avs_readdata), .address(avs_address), .read(avs_read),
      .write(avs_write), .writedata(avs_writedata));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic complete_run();
      $display("checks=%0d errors=%0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic acc(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
      bfm_u.xfer(wr, a, d, rd_q, ok);
      if (!ok) begin
         err_total++;
         complete_run();
      end
   endtask
   // Expected {low_power, enable}
   function automatic logic [1:0] mode_exp(input logic [1:0] st, input logic [3:0] c);
      logic on;
      on = c[0] && (st == 2'h0 || (st == 2'h1 && c[1]) || (st == 2'h2 && c[2]));
      return {on && st != 2'h0 && c[3], on};
   endfunction
   initial begin
      logic [1:0] e;
      repeat (8) @(posedge clk_sys);
      rst <= 1'b0;
      acc(0, OFF_CTRL, 0);
      chk(rd_q, 0);
      chk({discharge_en, vout_mv}, {1'b1, 12'd1800});
      for (int k = 0; k < 16; k++) begin
         acc(1, OFF_VOUT, k);
         repeat (2) @(posedge clk_sys);
         chk(vout_mv, 1800 + 100 * k);
         chk(vout_code, k);
      end
      $display("test vout done");
      for (int s = 0; s < 4; s++) begin
         power_state <= s[1:0];
         for (int c = 0; c < 16; c++) begin
            acc(1, OFF_CTRL, c);
            repeat (4) @(posedge clk_sys);
            e = mode_exp(s[1:0], c[3:0]);
            chk({reg_low_power, reg_enable, discharge_en}, {e, !e[0]});
         end
      end
      $display("test mode done");
      power_state <= 2'h0;
      acc(1, OFF_CTRL, 1);
      processor_reset_out_n <= 1'b0;
      repeat (5) @(posedge clk_sys);
      chk(discharge_en, 1);
      processor_reset_out_n <= 1'b1;
      overcurrent <= 1'b1;
      repeat (5) @(posedge clk_sys);
      chk({current_limit_mode, reg_enable, irq, discharge_en}, 4'he);
      overcurrent <= 1'b0;
      repeat (5) @(posedge clk_sys);
      chk(irq, 1);
      acc(0, OFF_STATUS, 0);
      chk({rd_q[0], irq}, 2'b10);
      acc(1, OFF_MASK, 1);
      overcurrent <= 1'b1;
      repeat (5) @(posedge clk_sys);
      chk(irq, 0);
      acc(1, OFF_MASK, 0);
      chk(irq, 1);
      overcurrent <= 1'b0;
      acc(0, OFF_STATUS, 0);
      $display("test limit done");
      acc(1, OFF_CTRL, 32'h11);
      overcurrent <= 1'b1;
      repeat (5) @(posedge clk_sys);
      chk({reg_enable, irq}, 2'b01);
      acc(0, OFF_CTRL, 0);
      chk(rd_q, 32'h10);
      overcurrent <= 1'b0;
      acc(0, OFF_STATUS, 0);
      chk(rd_q, 1);
      acc(0, OFF_STATUS, 0);
      chk(rd_q, 0);
      acc(1, 4'h2, 32'hffff_ffff);
      acc(0, 4'h2, 0);
      chk(rd_q, 0);
      $display("test shutdown done");
      complete_run();
   end
endmodule // tb_ldo_regulator_control
`default_nettype wire
